// File: rtl/dpd_top.sv
`timescale 1ns/1ps
`include "dpd_consts.svh"

module dpd_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // External clock and data ports (pins)
   input wire logic ext_clk_i,
   input wire logic [`DPD_CODE_W-1:0] port1_i,
   input wire logic [`DPD_CODE_W-1:0] port2_i,
   // Converter side
   input wire logic conv_ready_i,
   output logic conv_valid_o,
   output dpd_pkg::dpd_seg_type seg_primary_o,
   output dpd_pkg::dpd_seg_type seg_compl_o,
   output logic lock_indicator_o
);
   import dpd_pkg::*;

   // ==========================================================
   // Register file state
   logic [3:0] ctrl_q;
   logic overrun_q;
   logic [`DPD_CODE_W-1:0] last_code_q;
   logic [31:0] count_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic wr_ctrl;
   logic wr_stat;
   logic bus_req;

   // ==========================================================
   // Pin synchronisers
   logic clk_s1_q;
   logic clk_s2_q;
   logic clk_s3_q;
   dpd_pair_type pins_s1_q;
   dpd_pair_type pins_s2_q;
   logic ext_rise;

   // ==========================================================
   // Clocking and sequencing state
   logic mult_en;
   logic [1:0] range_sel;
   logic div_reset;
   logic forbidden;
   logic [`DPD_PERIOD_W-1:0] cnt_q;
   logic [`DPD_PERIOD_W-1:0] period_q;
   logic [`DPD_PERIOD_W-1:0] half;
   dpd_oseq_type os_q;
   dpd_pair_type latch_q;
   logic [`DPD_CODE_W-1:0] held_p2_q;
   logic phase_q;
   logic onex_rise;
   logic [3:0] fb_cnt_q;
   logic [3:0] fb_mod;
   logic [3:0] good_q;
   logic lock_q;

   // ==========================================================
   // Buffer interface
   logic push_valid;
   logic [`DPD_CODE_W-1:0] push_data;
   logic buf_ready;
   logic buf_valid;
   logic [`DPD_CODE_W-1:0] buf_data;
   logic out_take;
   dpd_seg_type seg_d;

   assign mult_en = ctrl_q[`DPD_CTRL_MULT_EN];
   assign range_sel = {ctrl_q[`DPD_CTRL_RANGE_HI], ctrl_q[`DPD_CTRL_RANGE_LO]};
   assign div_reset = ctrl_q[`DPD_CTRL_DIV_RESET] && !mult_en;
   assign forbidden = !mult_en && (dpd_port_mode_type'(range_sel) == DPD_PM_FORBIDDEN);

   // ==========================================================
   // Wishbone slave: ack one cycle after the strobe, dropped next cycle
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `DPD_ADDR_CTRL);
   assign wr_stat = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `DPD_ADDR_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= bus_req;
      end
   end

   // Read data latched with the ack; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0;
      end else if (ce_i && bus_req) begin
         unique case (wb_adr_i)
            `DPD_ADDR_CTRL: rdata_q <= {28'h0, ctrl_q};
            `DPD_ADDR_STATUS: rdata_q <= {period_q, 12'h0, overrun_q, forbidden, mult_en, lock_q};
            `DPD_ADDR_CODE: rdata_q <= {18'h0, last_code_q};
            `DPD_ADDR_COUNT: rdata_q <= count_q;
            default: rdata_q <= 32'h0;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   // Control register: enable, range select, divider reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `DPD_CTRL_RESET;
      end else if (ce_i && wr_ctrl) begin
         ctrl_q <= wb_dat_i[3:0];
      end
   end

   // Overrun sticky: a word lost in the same cycle as the clear still sets it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overrun_q <= 1'b0;
      end else if (ce_i) begin
         if (push_valid && !buf_ready) begin
            overrun_q <= 1'b1;
         end else if (wr_stat && wb_dat_i[`DPD_STAT_OVERRUN]) begin
            overrun_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Two flops on every pin, a third on the clock for edge detect; clock and data share the delay so they stay aligned
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
         pins_s1_q <= '0;
         pins_s2_q <= '0;
      end else if (ce_i) begin
         clk_s1_q <= ext_clk_i;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         pins_s1_q <= {port1_i, port2_i};
         pins_s2_q <= pins_s1_q;
      end
   end

   assign ext_rise = clk_s2_q && !clk_s3_q;

   // ==========================================================
   // Period measurement on rising edges only, so duty cycle does not matter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         period_q <= '0;
      end else if (ce_i) begin
         if (ext_rise) begin
            cnt_q <= `DPD_PERIOD_W'(1);
            period_q <= cnt_q;
         end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + `DPD_PERIOD_W'(1);
         end
      end
   end

   assign half = period_q >> 1;

   // ==========================================================
   // Internal 1x phase with the multiplier off; divider reset forces it high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= 1'b0;
      end else if (ce_i) begin
         if (div_reset) begin
            phase_q <= 1'b1;
         end else if (ext_rise) begin
            phase_q <= !phase_q;
         end
      end
   end

   assign onex_rise = ext_rise && !phase_q && !div_reset;

   // ==========================================================
   // Input latches: both ports on one edge, only the selected port in the single-port modes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_q <= '0;
         held_p2_q <= '0;
      end else if (ce_i) begin
         if (mult_en && ext_rise) begin
            latch_q <= pins_s2_q;
            held_p2_q <= latch_q.port2;
         end else if (!mult_en && onex_rise && !forbidden) begin
            unique case (dpd_port_mode_type'(range_sel))
               DPD_PM_PORT1: latch_q.port1 <= pins_s2_q.port1;
               DPD_PM_PORT2: latch_q.port2 <= pins_s2_q.port2;
               default: latch_q <= pins_s2_q;
            endcase
         end
      end
   end

   // ==========================================================
   // Output sequencer: port 2 on the edge, port 1 half a period later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         os_q <= DPD_OS_IDLE;
      end else if (ce_i) begin
         unique case (os_q)
            DPD_OS_IDLE: begin
               if (mult_en && ext_rise) begin
                  os_q <= DPD_OS_WAIT;
               end else if (!mult_en && onex_rise && !forbidden
                            && dpd_port_mode_type'(range_sel) == DPD_PM_INTERLEAVED) begin
                  os_q <= DPD_OS_WAIT;
               end
            end
            DPD_OS_WAIT: begin
               if (!mult_en && ext_rise) begin
                  os_q <= DPD_OS_EMIT; // Next 2x edge with the multiplier off
               end else if (mult_en && cnt_q >= half) begin
                  os_q <= DPD_OS_EMIT;
               end
            end
            DPD_OS_EMIT: begin
               os_q <= DPD_OS_IDLE;
            end
            default: begin
               os_q <= DPD_OS_IDLE;
            end
         endcase
      end
   end

   // Words offered to the buffer; at most one per cycle
   always_comb begin
      push_valid = 1'b0;
      push_data = latch_q.port2;
      if (os_q == DPD_OS_EMIT) begin
         push_valid = 1'b1;
         push_data = latch_q.port1;
      end else if (mult_en && ext_rise) begin
         push_valid = 1'b1;
         push_data = latch_q.port2;
      end else if (!mult_en && onex_rise && !forbidden) begin
         push_valid = 1'b1;
         unique case (dpd_port_mode_type'(range_sel))
            DPD_PM_PORT1: push_data = latch_q.port1;
            default: push_data = latch_q.port2;
         endcase
      end
   end

   // ==========================================================
   // Feedback divider and phase check; the prescaler stretches the check
   // interval so slow input clocks still see the oscillator in its span
   assign fb_mod = 4'h1 << range_sel;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fb_cnt_q <= 4'h0;
         good_q <= 4'h0;
         lock_q <= 1'b0;
      end else if (ce_i) begin
         if (!mult_en) begin
            fb_cnt_q <= 4'h0;
            good_q <= 4'h0;
            lock_q <= 1'b0;
         end else if (ext_rise) begin
            fb_cnt_q <= (fb_cnt_q + 4'h1 >= fb_mod) ? 4'h0 : fb_cnt_q + 4'h1;
            if (fb_cnt_q == 4'h0) begin
               // Phase good when the period held within one cycle
               if ((period_q - cnt_q <= `DPD_PERIOD_W'(1)) || (cnt_q - period_q <= `DPD_PERIOD_W'(1))) begin
                  good_q <= (good_q == `DPD_LOCK_CHECKS) ? good_q : good_q + 4'h1;
                  lock_q <= (good_q >= `DPD_LOCK_CHECKS - 4'h1);
               end else begin
                  good_q <= 4'h0;
                  lock_q <= 1'b0;
               end
            end
         end
      end
   end

   // Lock pin: phase result when active, the 1x clock when off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_indicator_o <= 1'b0;
      end else if (ce_i) begin
         lock_indicator_o <= mult_en ? lock_q : phase_q;
      end
   end

   // ==========================================================
   // Two-entry buffer absorbs a converter stall of up to two words; later words are lost and set overrun
   dpd_buf2 #(
      .WIDTH(`DPD_CODE_W),
      .DEPTH(2)
   ) u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(push_valid),
      .in_ready_o(buf_ready),
      .in_data_i(push_data),
      .out_valid_o(buf_valid),
      .out_ready_i(out_take),
      .out_data_o(buf_data)
   );

   assign out_take = buf_valid && (conv_ready_i || !conv_valid_o);

   // ==========================================================
   // Segment decoder
   always_comb begin
      seg_d = '0;
      for (int i = 0; i < `DPD_HI_SEGS; i++) begin
         seg_d.therm_hi[i] = (buf_data[`DPD_HI_MSB:`DPD_HI_LSB] > 5'(i));
      end
      for (int j = 0; j < `DPD_MID_SEGS; j++) begin
         seg_d.therm_mid[j] = (buf_data[`DPD_MID_MSB:`DPD_MID_LSB] > 4'(j));
      end
      seg_d.bin = buf_data[`DPD_BIN_W-1:0];
   end

   // Output latch: one word per cycle keeps pace with the doubled rate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seg_primary_o <= '0;
         seg_compl_o <= '1;
         conv_valid_o <= 1'b0;
      end else if (ce_i) begin
         if (out_take) begin
            seg_primary_o <= seg_d;
            seg_compl_o <= ~seg_d;
            conv_valid_o <= 1'b1;
         end else if (conv_ready_i) begin
            conv_valid_o <= 1'b0;
         end
      end
   end

   // Last code and word count for software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_code_q <= '0;
         count_q <= 32'h0;
      end else if (ce_i && out_take) begin
         last_code_q <= buf_data;
         count_q <= count_q + 32'h1;
      end
   end

endmodule : dpd_top

// File: rtl/dpd_consts.svh
`ifndef DPD_CONSTS_SVH
`define DPD_CONSTS_SVH

// ==========================================================
// Register map (byte addresses on the Wishbone slave)
`define DPD_ADDR_CTRL 8'h00
`define DPD_ADDR_STATUS 8'h04
`define DPD_ADDR_CODE 8'h08
`define DPD_ADDR_COUNT 8'h0c

// ==========================================================
// Control register fields
`define DPD_CTRL_MULT_EN 0
`define DPD_CTRL_RANGE_LO 1
`define DPD_CTRL_RANGE_HI 2
`define DPD_CTRL_DIV_RESET 3
`define DPD_CTRL_RESET 4'h0

// ==========================================================
// Status register fields
`define DPD_STAT_LOCK 0
`define DPD_STAT_ACTIVE 1
`define DPD_STAT_FORBIDDEN 2
`define DPD_STAT_OVERRUN 3
`define DPD_STAT_PERIOD_LSB 16

// ==========================================================
// Code layout
`define DPD_CODE_W 14
`define DPD_HI_MSB 13
`define DPD_HI_LSB 9
`define DPD_MID_MSB 8
`define DPD_MID_LSB 5
`define DPD_HI_SEGS 31
`define DPD_MID_SEGS 15
`define DPD_BIN_W 5

// ==========================================================
// Lock detector: consecutive good phase checks before lock
`define DPD_LOCK_CHECKS 4'h4
`define DPD_PERIOD_W 16

`endif

// File: rtl/dpd_pkg.sv
`include "dpd_consts.svh"

package dpd_pkg;

   // Port mode with the multiplier disabled
   typedef enum logic [1:0] {
      DPD_PM_INTERLEAVED = 2'b00,
      DPD_PM_PORT1 = 2'b01,
      DPD_PM_PORT2 = 2'b10,
      DPD_PM_FORBIDDEN = 2'b11
   } dpd_port_mode_type;

   // Output sequencer states, Gray from IDLE through WAIT to EMIT; EMIT back to IDLE flips both bits
   typedef enum logic [1:0] {
      DPD_OS_IDLE = 2'b00,
      DPD_OS_WAIT = 2'b01,
      DPD_OS_EMIT = 2'b11
   } dpd_oseq_type;

   // Segment switch controls for one output side
   typedef struct packed {
      logic [`DPD_HI_SEGS-1:0] therm_hi;
      logic [`DPD_MID_SEGS-1:0] therm_mid;
      logic [`DPD_BIN_W-1:0] bin;
   } dpd_seg_type;

   // Pair of words captured on one external edge
   typedef struct packed {
      logic [`DPD_CODE_W-1:0] port1;
      logic [`DPD_CODE_W-1:0] port2;
   } dpd_pair_type;

endpackage : dpd_pkg

// File: rtl/dpd_buf2.sv
`timescale 1ns/1ps
`include "dpd_consts.svh"

// Two-entry buffer between the port multiplexer and the output latch
module dpd_buf2 #(
   parameter int WIDTH = `DPD_CODE_W,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // ==========================================================
   // Flow control
   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Storage, no reset needed on data
   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers wrap at DEPTH
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (ce_i) begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         end
      end
   end

   // Occupancy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (ce_i) begin
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end

endmodule : dpd_buf2

// File: dv/dpd_top_chk.sv
`timescale 1ns/1ps
`include "dpd_consts.svh"
// ==========================================================
// Port-level checker for the converter front end
module dpd_top_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ext_clk_i,
   input wire logic [`DPD_CODE_W-1:0] port1_i,
   input wire logic [`DPD_CODE_W-1:0] port2_i,
   input wire logic conv_ready_i,
   input wire logic conv_valid_o,
   input wire dpd_pkg::dpd_seg_type seg_primary_o,
   input wire dpd_pkg::dpd_seg_type seg_compl_o,
   input wire logic lock_indicator_o
);
   import dpd_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Both output sides must always be exact complements
   property p_compl; seg_compl_o == ~seg_primary_o; endproperty
   // Thermometer fields fill from bit 0 with no holes
   property p_therm_hi; ((seg_primary_o.therm_hi + 31'h1) & seg_primary_o.therm_hi) == 31'h0; endproperty
   property p_therm_mid; ((seg_primary_o.therm_mid + 15'h1) & seg_primary_o.therm_mid) == 15'h0; endproperty
   // Bus answers one cycle after the request is taken, for one cycle only
   property p_ack_resp; ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
   // A stalled word must not be lost or altered
   property p_hold; conv_valid_o && !conv_ready_i && ce_i |=> conv_valid_o && $stable(seg_primary_o); endproperty
   // Outputs come out of reset quiet
   property p_reset; $fell(rst_i) |-> !conv_valid_o && !wb_ack_o && !lock_indicator_o && seg_primary_o == '0;
   endproperty
   // Clock enable low freezes the output side
   property p_freeze; !ce_i |=> $stable(seg_primary_o) && $stable(conv_valid_o) && $stable(lock_indicator_o);
   endproperty

   a_compl: assert property (p_compl) else $error("outputs not complementary");
   a_therm_hi: assert property (p_therm_hi) else $error("upper field not thermometer");
   a_therm_mid: assert property (p_therm_mid) else $error("middle field not thermometer");
   a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_hold: assert property (p_hold) else $error("stalled word changed");
   a_reset: assert property (p_reset) else $error("outputs not at reset values");
   a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");

   c_accept: cover property (conv_valid_o && conv_ready_i);
   c_lock: cover property ($rose(lock_indicator_o));
   c_stall: cover property ((conv_valid_o && !conv_ready_i) [*8]);
endmodule : dpd_top_chk

bind dpd_top dpd_top_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i), .port1_i(port1_i),
   .port2_i(port2_i), .conv_ready_i(conv_ready_i), .conv_valid_o(conv_valid_o),
   .seg_primary_o(seg_primary_o), .seg_compl_o(seg_compl_o), .lock_indicator_o(lock_indicator_o)
);

// File: dv/dpd_src_model.sv
`timescale 1ns/1ps
// ==========================================================
// Source logic driving the external clock and both data ports
module dpd_src_model #(
   parameter int HALF = 8,
   parameter logic [13:0] STEP = 14'h0a5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic ext_clk_o,
   output logic [13:0] port1_o,
   output logic [13:0] port2_o
);
   int cnt;
   logic [13:0] word_q;

   // Steady period keeps the clock inside the band of every range
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         ext_clk_o <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         ext_clk_o <= !ext_clk_o;
      end else begin
         cnt <= cnt + 1;
      end
   end

   // New words at the falling edge, so they stand settled at the rising edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_q <= 14'h0;
         port1_o <= 14'h0;
         port2_o <= 14'h0;
      end else if (cnt == HALF - 1 && ext_clk_o) begin
         port1_o <= word_q;
         port2_o <= word_q + STEP;
         word_q <= word_q + {STEP[12:0], 1'b0};
      end
   end
endmodule : dpd_src_model

// File: dv/test_dual_port_dac_clock_interface.sv
`timescale 1ns/1ps
`include "dpd_consts.svh"
// ==========================================================
// Self-checking bench for the converter front end
module test_dual_port_dac_clock_interface;
   import dpd_pkg::*;
   localparam logic [13:0] STEP = 14'h0a5;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, conv_ready_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, ext_clk_i, conv_valid_o, lock_indicator_o;
   logic [7:0] wb_adr_i = 8'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [13:0] port1_i, port2_i, prev_code = 14'h0, exp_step = 14'h0;
   dpd_seg_type seg_primary_o, seg_compl_o;
   int num_errors = 0, n_checks = 0, mon_cnt = 0, mon_skip = 0, mon_on = 0, c0;

   initial forever #12.5 clk_i = ~clk_i;

   dpd_src_model #(.HALF(8), .STEP(STEP)) u_src (.clk_i(clk_i), .rst_i(rst_i), .ext_clk_o(ext_clk_i),
      .port1_o(port1_i), .port2_o(port2_i));
   dpd_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i), .port1_i(port1_i), .port2_i(port2_i),
      .conv_ready_i(conv_ready_i), .conv_valid_o(conv_valid_o), .seg_primary_o(seg_primary_o),
      .seg_compl_o(seg_compl_o), .lock_indicator_o(lock_indicator_o));

   // ==========================================================
   // Code to segment controls and back
   function automatic dpd_seg_type enc(input logic [13:0] c);
      dpd_seg_type s;
      s.therm_hi = (31'h1 << c[13:9]) - 31'h1;
      s.therm_mid = (15'h1 << c[8:5]) - 15'h1;
      s.bin = c[4:0];
      return s;
   endfunction : enc
   function automatic logic [13:0] dec(input dpd_seg_type s);
      return {5'($countones(s.therm_hi)), 4'($countones(s.therm_mid)), s.bin};
   endfunction : dec

   task automatic print_verdict;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_word
   task automatic check_seg(input dpd_seg_type got, input dpd_seg_type exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_seg

   // ==========================================================
   // Accepted words sampled mid-cycle, away from the launching edge
   always @(negedge clk_i) begin
      if (!rst_i && ce_i && conv_valid_o === 1'b1 && conv_ready_i) begin
         check_seg(seg_primary_o, enc(dec(seg_primary_o)));
         if (mon_skip > 0) mon_skip--;
         else if (mon_on) check_word({18'h0, dec(seg_primary_o)}, {18'h0, prev_code + exp_step});
         prev_code = dec(seg_primary_o);
         mon_cnt++;
      end
   end

   // ==========================================================
   // Wishbone classic master; ack and read data taken at the rising edge, request held until then
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         print_verdict();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb_xfer
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
      wb_xfer(1'b0, adr, 32'h0);
      check_word(rd & mask, exp);
   endtask : rd_chk
   task automatic set_mode(input logic [31:0] ctrl, input logic [13:0] step);
      mon_on = 0;
      wb_xfer(1'b1, `DPD_ADDR_CTRL, ctrl);
      exp_step = step;
      mon_skip = 4;
      mon_on = 1;
   endtask : set_mode
   task automatic wait_lock;
      int n;
      n = 0;
      while (lock_indicator_o !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      check_word({31'h0, lock_indicator_o}, 32'h1);
      if (n >= 3000) print_verdict();
   endtask : wait_lock

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      check_seg(seg_compl_o, '1);
      rd_chk(`DPD_ADDR_CTRL, 32'hffff_ffff, 32'h0);
      wb_xfer(1'b1, 8'h10, 32'hffff_ffff);
      rd_chk(8'h10, 32'hffff_ffff, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_ranges;
      for (int r = 0; r < 4; r++) begin
         set_mode(32'h0, STEP);
         rd_chk(`DPD_ADDR_STATUS, 32'h3, 32'h0);
         set_mode({29'h0, 2'(r), 1'b1}, STEP);
         wait_lock();
         repeat (400) @(posedge clk_i);
         rd_chk(`DPD_ADDR_STATUS, 32'h3, 32'h3);
      end
      $display("t_ranges done");
   endtask : t_ranges
   task automatic t_divrst;
      c0 = mon_cnt;
      wb_xfer(1'b1, `DPD_ADDR_CTRL, 32'h9);
      repeat (400) @(posedge clk_i);
      check_word({31'h0, lock_indicator_o}, 32'h1);
      check_word(32'(mon_cnt - c0 > 40), 32'h1);
      $display("t_divrst done");
   endtask : t_divrst
   task automatic t_single;
      for (int m = 1; m < 3; m++) begin
         set_mode({29'h0, 2'(m), 1'b0}, {STEP[11:0], 2'b00});
         c0 = mon_cnt;
         repeat (600) @(posedge clk_i);
         check_word(32'(mon_cnt - c0 > 8), 32'h1);
      end
      $display("t_single done");
   endtask : t_single
   task automatic t_forbid;
      set_mode(32'h6, 14'h0);
      mon_on = 0;
      repeat (100) @(posedge clk_i);
      wb_xfer(1'b0, `DPD_ADDR_COUNT, 32'h0);
      c0 = rd;
      repeat (400) @(posedge clk_i);
      rd_chk(`DPD_ADDR_COUNT, 32'hffff_ffff, c0);
      rd_chk(`DPD_ADDR_STATUS, 32'h4, 32'h4);
      $display("t_forbid done");
   endtask : t_forbid
   task automatic t_stall;
      set_mode(32'h1, STEP);
      wait_lock();
      conv_ready_i <= 1'b0;
      repeat (200) @(posedge clk_i);
      check_word({31'h0, conv_valid_o}, 32'h1);
      rd_chk(`DPD_ADDR_STATUS, 32'h8, 32'h8);
      mon_skip = 6;
      conv_ready_i <= 1'b1;
      repeat (50) @(posedge clk_i);
      wb_xfer(1'b1, `DPD_ADDR_STATUS, 32'h8);
      rd_chk(`DPD_ADDR_STATUS, 32'h8, 32'h0);
      ce_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      mon_skip = 6;
      ce_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      $display("t_stall done");
   endtask : t_stall

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_ranges();
      t_divrst();
      t_single();
      t_forbid();
      t_stall();
      print_verdict();
   end
endmodule : test_dual_port_dac_clock_interface
